// >>> core/lsrd_host.sv
// link-side controller sending service request streams to the device
// Functional notes
// - bus request 11 bits, register read 10, register write 18 bits
// - notifications (types 1100 to 1110) are six bits long
// - every stream starts with a one; all but the short bus request, which has no stop, end with a zero
// - type code in bits one to four, msb first after start
// - request line stays low between streams
// - types 1100 and 1101 notify cycle start seen and phase set
// - type 1110 notifies that a cycle start reception is due
// - bus request bit five selects beta format when one
// - bus request bits six to nine give the data speed
// - speed codes 0,2,4,6 valid; 1,3,5 reserved; others invalid
// - read request carries register address in bits five to eight
// - request bits driven synchronous to the returned link clock
// - write request carries address, eight data bits, stop at seventeen
`timescale 1ns/1ns
module lsrd_host
  import lsrd_pkg::*;
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  // software register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  // link pins toward the device
  output logic                   LINK_RETURN_CLOCK,
  output logic                   LINK_REQUEST_LINE
);
  typedef enum {
    ST_IDLE,
    ST_LOAD,
    ST_SEND
  } lsrd_state_t;

  logic              rst_meta;
  logic              rst_n;
  logic              fall_en;
  logic [9:0]        cfg;
  logic [9:0]        next_cfg;
  logic [11:0]       arg;
  logic [11:0]       next_arg;
  logic              refused;
  logic              next_refused;
  logic              overlap;
  logic              next_overlap;
  logic [7:0]        sent_cnt;
  logic [7:0]        next_sent_cnt;
  logic [DATA_W-1:0] next_rdata;
  lsrd_state_t       state;
  lsrd_state_t       next_state;
  logic [FRAME_W-1:0] frame;
  logic [FRAME_W-1:0] next_frame;
  logic [LEN_W-1:0]  len;
  logic [LEN_W-1:0]  next_len;
  lsrd_req_t         req_type;
  logic              req_fmt;
  logic [3:0]        req_spd;
  logic              short_en;
  logic [3:0]        reg_addr;
  logic [7:0]        reg_data;
  logic              go;
  logic              legal;
  logic [FRAME_W-1:0] build_frame;
  logic [LEN_W-1:0]  build_len;

  lsrd_ser_if sif ();

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // returned link clock made here from the core clock
  lsrd_clkdiv u_div (
    .clk      (CORE_CLK),
    .rst_n    (rst_n),
    .link_clk (LINK_RETURN_CLOCK),
    .fall_en  (fall_en)
  );

  // bit shifter driving the request line
  lsrd_ser u_ser (
    .clk     (CORE_CLK),
    .rst_n   (rst_n),
    .fall_en (fall_en),
    .sif     (sif.ser),
    .line    (LINK_REQUEST_LINE)
  );

  // field views of the software registers
  always_comb begin
    req_type = lsrd_req_t'(cfg[CFG_TYPE_LSB +: 4]);
    req_fmt  = cfg[CFG_FMT_BIT];
    req_spd  = cfg[CFG_SPD_LSB +: 4];
    short_en = cfg[CFG_SHORT_BIT];
    reg_addr = arg[ARG_ADDR_LSB +: 4];
    reg_data = arg[ARG_DATA_LSB +: 8];
    go       = REG_WR && (REG_ADDR == OFS_REQ_GO);
  end

  // frame and length per request type, left aligned, msb sent first
  always_comb begin
    legal       = 1'b1;
    build_frame = '0;
    build_len   = LEN_NOTIFY;
    case (req_type)
      REQ_IMMED, REQ_NEXT_EVEN, REQ_NEXT_ODD, REQ_CURRENT, REQ_ISO_EVEN, REQ_ISO_ODD, REQ_CYC_START: begin
        build_frame = {START_BIT, req_type, req_fmt, req_spd, STOP_BIT, 7'h00};
        build_len   = LEN_BUS;
        if (short_en && !req_spd[3]) begin
          build_len = LEN_BUS_SHORT;
        end
        if (req_spd == SPD_RSV1 || req_spd == SPD_RSV3 || req_spd == SPD_RSV5) begin
          legal = 1'b0;
        end
        // codes above six are invalid but still sent
      end
      REQ_REG_READ: begin
        build_frame = {START_BIT, req_type, reg_addr, STOP_BIT, 8'h00};
        build_len   = LEN_READ;
      end
      REQ_REG_WRITE: begin
        build_frame = {START_BIT, req_type, reg_addr, reg_data, STOP_BIT};
        build_len   = LEN_WRITE;
      end
      REQ_PH_EVEN, REQ_PH_ODD, REQ_CYC_DUE: begin
        build_frame = {START_BIT, req_type, STOP_BIT, 12'h000};
        build_len   = LEN_NOTIFY;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // request sequencer
  always_comb begin
    next_state    = state;
    next_frame    = frame;
    next_len      = len;
    sif.load      = 1'b0;
    sif.frame     = frame;
    sif.len       = len;
    next_sent_cnt = sent_cnt;
    case (state)
      ST_IDLE: begin
        if (go && legal) begin
          next_frame = build_frame;
          next_len   = build_len;
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        sif.load = 1'b1;
        if (!sif.busy) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (sif.done) begin
          next_sent_cnt = sent_cnt + 8'h01;
          next_state    = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // register writes and sticky flags, hardware set wins over clear
  always_comb begin
    next_cfg     = cfg;
    next_arg     = arg;
    next_refused = refused;
    next_overlap = overlap;
    if (REG_WR) begin
      if (REG_ADDR == OFS_REQ_CFG) begin
        next_cfg = REG_WDATA[9:0];
      end else if (REG_ADDR == OFS_REQ_ARG) begin
        next_arg = REG_WDATA[11:0];
      end else if (REG_ADDR == OFS_STATUS) begin
        if (REG_WDATA[ST_REFUSE_BIT]) begin
          next_refused = 1'b0;
        end
        if (REG_WDATA[ST_OVER_BIT]) begin
          next_overlap = 1'b0;
        end
      end
    end
    if (go && state == ST_IDLE && !legal) begin
      next_refused = 1'b1;
    end
    if (go && state != ST_IDLE) begin
      next_overlap = 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (REG_RD) begin
      if (REG_ADDR == OFS_REQ_CFG) begin
        next_rdata = {6'h00, cfg};
      end else if (REG_ADDR == OFS_REQ_ARG) begin
        next_rdata = {4'h0, arg};
      end else if (REG_ADDR == OFS_STATUS) begin
        next_rdata[ST_BUSY_BIT]           = (state != ST_IDLE);
        next_rdata[ST_REFUSE_BIT]         = refused;
        next_rdata[ST_OVER_BIT]           = overlap;
        next_rdata[ST_CNT_LSB +: 8]       = sent_cnt;
      end
    end
  end

  // register all controller state
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      frame     <= '0;
      len       <= '0;
      cfg       <= CFG_RESET;
      arg       <= ARG_RESET;
      refused   <= 1'b0;
      overlap   <= 1'b0;
      sent_cnt  <= '0;
      REG_RDATA <= '0;
    end else begin
      state     <= next_state;
      frame     <= next_frame;
      len       <= next_len;
      cfg       <= next_cfg;
      arg       <= next_arg;
      refused   <= next_refused;
      overlap   <= next_overlap;
      sent_cnt  <= next_sent_cnt;
      REG_RDATA <= next_rdata;
    end
  end
endmodule

// >>> inc/lsrd_pkg.sv
// constants and types shared by the request stream controller
package lsrd_pkg;
  // clock timing
  localparam int CORE_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS  = 80;
  localparam int LINK_HALF_CYC   = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam int DIV_W           = 8;

  // software port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int FRAME_W = 18;
  localparam int LEN_W  = 5;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_REQ_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REQ_ARG = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_REQ_GO  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h3;

  // field positions of the configuration register
  localparam int CFG_TYPE_LSB  = 0;
  localparam int CFG_FMT_BIT   = 4;
  localparam int CFG_SPD_LSB   = 5;
  localparam int CFG_SHORT_BIT = 9;
  // field positions of the argument register
  localparam int ARG_ADDR_LSB  = 0;
  localparam int ARG_DATA_LSB  = 4;
  // field positions of the status register
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_REFUSE_BIT = 1;
  localparam int ST_OVER_BIT   = 2;
  localparam int ST_CNT_LSB    = 8;

  // reset values
  localparam logic [9:0]  CFG_RESET = 10'h000;
  localparam logic [11:0] ARG_RESET = 12'h000;

  // stream lengths in bits, start and stop included, except the short bus request, which has no stop
  localparam logic [LEN_W-1:0] LEN_BUS       = 5'd11;
  localparam logic [LEN_W-1:0] LEN_BUS_SHORT = 5'd10;
  localparam logic [LEN_W-1:0] LEN_READ      = 5'd10;
  localparam logic [LEN_W-1:0] LEN_WRITE     = 5'd18;
  localparam logic [LEN_W-1:0] LEN_NOTIFY    = 5'd6;

  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT  = 1'b0;

  // request type codes
  typedef enum logic [3:0] {
    REQ_RSV0      = 4'h0,
    REQ_IMMED     = 4'h1,
    REQ_NEXT_EVEN = 4'h2,
    REQ_NEXT_ODD  = 4'h3,
    REQ_CURRENT   = 4'h4,
    REQ_RSV5      = 4'h5,
    REQ_ISO_EVEN  = 4'h6,
    REQ_ISO_ODD   = 4'h7,
    REQ_CYC_START = 4'h8,
    REQ_RSV9      = 4'h9,
    REQ_REG_READ  = 4'hA,
    REQ_REG_WRITE = 4'hB,
    REQ_PH_EVEN   = 4'hC,
    REQ_PH_ODD    = 4'hD,
    REQ_CYC_DUE   = 4'hE,
    REQ_RSVF      = 4'hF
  } lsrd_req_t;

  // speed codes
  localparam logic [3:0] SPD_S100  = 4'h0;
  localparam logic [3:0] SPD_RSV1  = 4'h1;
  localparam logic [3:0] SPD_S200  = 4'h2;
  localparam logic [3:0] SPD_RSV3  = 4'h3;
  localparam logic [3:0] SPD_S400  = 4'h4;
  localparam logic [3:0] SPD_RSV5  = 4'h5;
  localparam logic [3:0] SPD_S800  = 4'h6;
endpackage

// >>> inc/lsrd_ser_if.sv
// link between the request controller and its bit serializer
`timescale 1ns/1ns
interface lsrd_ser_if;
  import lsrd_pkg::*;
  logic               load;
  logic [FRAME_W-1:0] frame;
  logic [LEN_W-1:0]   len;
  logic               busy;
  logic               done;
  modport ctl (output load, output frame, output len, input busy, input done);
  modport ser (input load, input frame, input len, output busy, output done);
endinterface

// >>> core/lsrd_clkdiv.sv
// divider making the returned link clock and its falling-edge enable
`timescale 1ns/1ns
module lsrd_clkdiv
  import lsrd_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // divided outputs
  output logic      link_clk,
  output logic      fall_en
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_link_clk;
  logic             wrap;

  // half period counter and toggle
  always_comb begin
    wrap          = (cnt == DIV_W'(LINK_HALF_CYC - 1));
    next_cnt      = wrap ? '0 : cnt + 8'h01;
    next_link_clk = wrap ? ~link_clk : link_clk;
    fall_en       = wrap & link_clk;  // clock about to go low
  end

  // register the divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= '0;
      link_clk <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      link_clk <= next_link_clk;
    end
  end
endmodule

// >>> core/lsrd_ser.sv
// serializer shifting a request frame out msb first on the link clock
`timescale 1ns/1ns
module lsrd_ser
  import lsrd_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // bit enable
  input  wire logic fall_en,
  // control side
  lsrd_ser_if.ser   sif,
  // request line
  output logic      line
);
  logic [FRAME_W-1:0] sh;
  logic [FRAME_W-1:0] next_sh;
  logic [LEN_W-1:0]   cnt;
  logic [LEN_W-1:0]   next_cnt;
  logic               pend;
  logic               next_pend;
  logic               next_line;
  logic               next_busy;
  logic               next_done;

  // shift one bit per link clock, line low when idle
  always_comb begin
    next_sh   = sh;
    next_cnt  = cnt;
    next_pend = pend;
    next_line = line;
    next_busy = sif.busy;
    next_done = 1'b0;
    if (sif.load && !sif.busy) begin
      next_sh   = sif.frame;
      next_cnt  = sif.len;
      next_pend = 1'b1;
      next_busy = 1'b1;
    end else if (fall_en && sif.busy) begin
      if (cnt != '0) begin
        next_line = sh[FRAME_W-1];
        next_sh   = {sh[FRAME_W-2:0], 1'b0};
        next_cnt  = cnt - 5'd1;
        next_pend = 1'b0;
      end else if (!pend) begin
        next_line = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // register the serializer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh       <= '0;
      cnt      <= '0;
      pend     <= 1'b0;
      line     <= 1'b0;
      sif.busy <= 1'b0;
      sif.done <= 1'b0;
    end else begin
      sh       <= next_sh;
      cnt      <= next_cnt;
      pend     <= next_pend;
      line     <= next_line;
      sif.busy <= next_busy;
      sif.done <= next_done;
    end
  end
endmodule

// >>> testbench/lsrd_host_checker.sv
// port assertions for the request stream controller
`timescale 1ns/1ns
module lsrd_host_checker
  import lsrd_pkg::*;
(
  // clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // link pins
  input wire logic              LINK_RETURN_CLOCK,
  input wire logic              LINK_REQUEST_LINE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // read data stands only after a read strobe
  property p_rd_idle;
    !REG_RD |=> REG_RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero without read");
  // go and unmapped places read as zero
  property p_rd_zero;
    REG_RD && (REG_ADDR == OFS_REQ_GO || REG_ADDR > OFS_STATUS) |=> REG_RDATA == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("go or unmapped read not zero");
  // configuration written reads back
  property p_cfg_back;
    REG_WR && REG_ADDR == OFS_REQ_CFG ##2 REG_RD && REG_ADDR == OFS_REQ_CFG
      |=> REG_RDATA == {6'h00, $past(REG_WDATA[9:0], 3)};
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("configuration readback wrong");
  // argument written reads back
  property p_arg_back;
    REG_WR && REG_ADDR == OFS_REQ_ARG ##2 REG_RD && REG_ADDR == OFS_REQ_ARG
      |=> REG_RDATA == {4'h0, $past(REG_WDATA[11:0], 3)};
  endproperty
  a_arg_back: assert property (p_arg_back) else $error("argument readback wrong");
  // link clock high for four cycles
  property p_clk_high;
    $rose(LINK_RETURN_CLOCK) |-> LINK_RETURN_CLOCK[*4] ##1 !LINK_RETURN_CLOCK;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high phase wrong");
  // link clock low for four cycles
  property p_clk_low;
    $fell(LINK_RETURN_CLOCK) |-> !LINK_RETURN_CLOCK[*4] ##1 LINK_RETURN_CLOCK;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("link clock low phase wrong");
  // line steady while link clock is high
  property p_line_hold;
    LINK_RETURN_CLOCK |-> $stable(LINK_REQUEST_LINE);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line moved during high clock");
  // each bit stands a full link period
  property p_bit_len;
    $changed(LINK_REQUEST_LINE) |=> $stable(LINK_REQUEST_LINE)[*7];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than a link period");
  // line low after reset release
  property p_idle_low;
    $rose(RESETN) |-> !LINK_REQUEST_LINE[*8];
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("line not low after reset");
  // main scenarios
  c_line: cover property (LINK_REQUEST_LINE);
  c_go: cover property (REG_WR && REG_ADDR == OFS_REQ_GO);
  c_status: cover property (REG_RD && REG_ADDR == OFS_STATUS);
endmodule

bind lsrd_host lsrd_host_checker chk_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .LINK_RETURN_CLOCK(LINK_RETURN_CLOCK), .LINK_REQUEST_LINE(LINK_REQUEST_LINE));

// >>> testbench/lsrd_dev_model.sv
// behavioural device receiving request streams
`timescale 1ns/1ns
module lsrd_dev_model
  import lsrd_pkg::*;
(
  // link pins
  input wire logic lclk,
  input wire logic line
);
  logic [17:0] sr = '0;
  logic [17:0] frm = '0;
  logic [4:0]  n = '0;
  logic [4:0]  nb = '0;
  logic [3:0]  typ = '0;
  logic [3:0]  ty;
  logic [7:0]  regs [16];
  int          cnt = 0;
  int          bad = 0;
  int          nulls = 0;
  // type known at bit five, latched after
  assign ty = (n == 5'd5) ? sr[3:0] : typ;
  // stream length by type
  function automatic int blen(logic [3:0] t);
    case (t)
      4'hA: return 10;
      4'hB: return 18;
      4'hC, 4'hD, 4'hE: return 6;
      default: return 11;
    endcase
  endfunction
  // sample once per link clock, start on a high bit
  always @(posedge lclk) begin
    if (n == 5'd0) begin
      if (line) begin
        n <= 5'd1;
        sr <= 18'h0_0001;
      end
    end else begin
      sr <= {sr[16:0], line};
      n <= n + 5'd1;
      if (n == 5'd5) typ <= sr[3:0];
      if (n >= 5'd5 && n + 1 == blen(ty)) begin
        n <= 5'd0;
        frm <= {sr[16:0], line};
        nb <= n + 5'd1;
        cnt <= cnt + 1;
        if (line || ty inside {4'h0, 4'h5, 4'h9, 4'hF}) bad <= bad + 1;
        else if (ty == 4'hB) regs[sr[11:8]] <= sr[7:0];
        else if (blen(ty) == 11 && sr[3:0] > 4'h6) nulls <= nulls + 1;
      end
    end
  end
endmodule

// >>> testbench/test_lsrd_host.sv
// self-checking bench for the request stream controller
`timescale 1ns/1ns
module test_lsrd_host;
  import lsrd_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic              lclk;
  logic              line;
  int                err_total = 0;
  int                total_checks = 0;
  int                nsent = 0;
  localparam logic [3:0]  BT [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
  localparam logic [3:0]  SP [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hF};
  localparam logic [3:0]  UA [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
  localparam logic [15:0] RSV [7] = '{16'h0000, 16'h0005, 16'h0009, 16'h000F, 16'h0021, 16'h0061, 16'h00A1};
  lsrd_host uut (.CORE_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .LINK_RETURN_CLOCK(lclk), .LINK_REQUEST_LINE(line));
  lsrd_dev_model dev (.lclk(lclk), .line(line));
  // core clock
  initial begin
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(string what, logic [17:0] seen, logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle register write
  task automatic wrr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // register read, data taken the cycle after
  task automatic rdr(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll status until not busy
  task automatic idle;
    v = 16'h0001;
    for (int i = 0; i < 50 && v[0]; i++) rdr(OFS_STATUS);
  endtask
  // send one stream and compare what the device saw
  // eb: busy still expected when the device has taken its last bit; low only for a short bus request
  task automatic send(logic [15:0] cfg, logic [15:0] arg, logic [17:0] ef, logic [4:0] en, logic eb = 1'b1);
    int c0;
    c0 = dev.cnt;
    wrr(OFS_REQ_CFG, cfg);
    wrr(OFS_REQ_ARG, arg);
    wrr(OFS_REQ_GO, 16'h0001);
    for (int i = 0; i < 400 && dev.cnt == c0; i++) @(posedge clk);
    nsent++;
    chk("frame", dev.frm, ef);
    chk("length", 18'(dev.nb), 18'(en));
    rdr(OFS_STATUS);
    chk("busy at end", 18'(v[0]), 18'(eb));
    idle();
  endtask
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #500_000;
    err_total++;
    finish_test();
  end
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (UA[i]) begin
      rdr(UA[i]);
      chk("reset read", 18'(v), 18'h0_0000);
    end
    wrr(OFS_REQ_CFG, 16'hFFFF);
    rdr(OFS_REQ_CFG);
    chk("cfg", 18'(v), 18'h0_03FF);
    wrr(OFS_REQ_ARG, 16'hFFFF);
    rdr(OFS_REQ_ARG);
    chk("arg", 18'(v), 18'h0_0FFF);
    // every bus request type with speeds and formats
    foreach (BT[i])
      send({7'h00, SP[i % 5], i[0], BT[i]}, 16'h0000,
        {7'h00, 1'b1, BT[i], i[0], SP[i % 5], 1'b0}, 5'd11);
    chk("null count", 18'(dev.nulls), 18'h0_0001);
    send(16'h0241, 16'h0000, {7'h00, 1'b1, 4'h1, 1'b0, 4'h2, 1'b0}, 5'd11, 1'b0);
    send(16'h000A, 16'h0005, {8'h00, 1'b1, 4'hA, 4'h5, 1'b0}, 5'd10);
    send(16'h000B, 16'h0A53, {1'b1, 4'hB, 4'h3, 8'hA5, 1'b0}, 5'd18);
    chk("device reg", 18'(dev.regs[3]), 18'h0_00A5);
    for (int t = 12; t < 15; t++)
      send(16'(t), 16'h0000, {12'h000, 1'b1, 4'(t), 1'b0}, 5'd6);
    // reserved types and speeds are refused
    foreach (RSV[i]) begin
      wrr(OFS_REQ_CFG, RSV[i]);
      wrr(OFS_REQ_GO, 16'h0001);
      rdr(OFS_STATUS);
      chk("refused", 18'(v[2:0]), 18'h0_0002);
      wrr(OFS_STATUS, 16'h0006);
    end
    chk("nothing sent", 18'(dev.cnt), 18'(nsent));
    chk("stop errors", 18'(dev.bad), 18'h0_0000);
    // second go while busy is dropped
    wrr(OFS_REQ_CFG, 16'h000C);
    wrr(OFS_REQ_GO, 16'h0001);
    rdr(OFS_STATUS);
    chk("busy", 18'(v[0]), 18'h0_0001);
    wrr(OFS_REQ_GO, 16'h0001);
    idle();
    nsent++;
    chk("overlap", 18'(v[2]), 18'h0_0001);
    chk("one stream", 18'(dev.cnt), 18'(nsent));
    rdr(OFS_STATUS);
    chk("count", 18'(v[15:8]), 18'(nsent));
    finish_test();
  end
endmodule
